/* File: hdl/i2c_pkg.sv */
package i2c_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] SADDR_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] EDGE_OFS = 8'h10;
    localparam logic [7:0] EVST_OFS = 8'h14;
    localparam logic [7:0] EVMASK_OFS = 8'h18;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int C_EN = 7;
    localparam int C_IE = 6;
    localparam int C_MST = 5;
    localparam int C_TX = 4;
    localparam int C_ACKV = 3;
    localparam int C_RPT = 2;
    localparam int C_FAST_ACK_CONTROL = 1;
    localparam int C_SMB = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hFB;
    localparam int S_ACK = 0;
    localparam int S_PEND = 1;
    localparam int S_ARB = 4;
    localparam int E_START = 4;
    localparam int E_EN = 5;
    localparam int E_STOP = 6;
    localparam int V_BYTE = 0;
    localparam int V_ADDR = 1;
    localparam int V_ARB = 2;
    localparam int V_EDGE = 3;
    localparam int V_TMO = 4;
    localparam int T_LOW = 0;
    localparam int T_SCLH = 1;
    localparam int T_SDAH = 2;

    // ****************************************************************
    // reset values, answers, timing
    // ****************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_EV = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS = 2500;
    localparam int HALF_INT = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] HALF_CYC = 10'(HALF_INT);
    localparam logic [9:0] TWO_HALF = 10'(2 * HALF_INT);
    localparam logic [9:0] THREE_HALF = 10'(3 * HALF_INT);

    typedef enum logic [5:0] {
        M_IDLE = 6'b000001,
        M_START = 6'b000010,
        M_HOLD = 6'b000100,
        M_XFER = 6'b001000,
        M_RPT = 6'b010000,
        M_STOP = 6'b100000
    } mst_e;

endpackage

/* File: hdl/i2c_data_port.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module i2c_data_port
    import i2c_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_b,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic ext_addr_match,
    input wire logic [2:0] smb_timeout,
    output logic irq
);

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == CTRL_OFS) || (a == DATA_OFS) || (a == SADDR_OFS) ||
            (a == STAT_OFS) || (a == EDGE_OFS) || (a == EVST_OFS) || (a == EVMASK_OFS);
    endfunction

    logic [7:0] wa;
    logic [7:0] ra_unused;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_fire;
    logic rd_fire;
    logic ctrl_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] ctrl;
    logic [7:0] own_addr;
    logic [4:0] ev_mask;
    logic [4:0] ev_stat;
    logic edge_en;
    logic start_seen;
    logic stop_seen;
    logic pending;
    logic arb_lost;
    logic ack_rx;
    logic tcf;
    logic addressed;
    logic slave_rw;
    logic busy;
    logic [7:0] data_reg;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start_det;
    logic stop_det;
    mst_e master_select_bit;
    logic [9:0] phase;
    logic xfer;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic tx_byte;
    logic addr_phase;
    logic m_addr;
    logic slv_wait;
    logic match;
    logic m_go;
    logic s_go;
    logic go;
    logic fall9;
    logic byte_flag;
    logic addr_evt;
    logic arb_evt;
    logic tmo_evt;
    logic edge_evt;
    logic [4:0] ev_set;
    logic [31:0] rd_mux;

    // ****************************************************************
    // pin synchronisers and bus condition detection
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign rise = scl_s && !scl_d;
    assign fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign wr_fire = !awready && !wready && !bvalid;
    assign rd_fire = arvalid && arready;
    assign ctrl_wr = wr_fire && (wa == CTRL_OFS) && ws[0];
    assign data_wr = wr_fire && (wa == DATA_OFS) && ws[0];
    assign data_rd = rd_fire && (araddr == DATA_OFS);
    assign ra_unused = 8'h00;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wa <= 8'h00;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready <= 1'b0;
                wa <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready <= 1'b0;
                wd <= wdata;
                ws <= wstrb;
            end
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp <= is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (araddr)
            CTRL_OFS: rd_mux[7:0] = ctrl;
            DATA_OFS: rd_mux[7:0] = data_reg;
            SADDR_OFS: rd_mux[7:0] = own_addr;
            STAT_OFS: rd_mux[7:0] = {tcf, addressed, busy, arb_lost, 1'b0, slave_rw,
                pending, ack_rx};
            EDGE_OFS: rd_mux[7:0] = {1'b0, stop_seen, edge_en, start_seen, 4'h0};
            EVST_OFS: rd_mux[4:0] = ev_stat;
            EVMASK_OFS: rd_mux[4:0] = ev_mask;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ****************************************************************
    // software control registers
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ctrl <= RST_BYTE;
            own_addr <= RST_BYTE;
            edge_en <= 1'b0;
            ev_mask <= RST_EV;
        end
        else
        begin
            if (ctrl_wr)
                ctrl <= wd[7:0] & CTRL_WMASK;
            if (arb_evt)
                ctrl[C_MST] <= 1'b0;
            if (wr_fire && (wa == SADDR_OFS) && ws[0])
                own_addr <= wd[7:0];
            if (wr_fire && (wa == EDGE_OFS) && ws[0])
                edge_en <= wd[E_EN];
            if (wr_fire && (wa == EVMASK_OFS) && ws[0])
                ev_mask <= wd[4:0];
        end
    end

    // ****************************************************************
    // event decode
    // ****************************************************************
    // own_addr[7:1] is the slave address, own_addr[0] enables general call
    assign match = (shreg[7:1] == own_addr[7:1]) || (own_addr[0] && (shreg == 8'h00)) ||
        ext_addr_match;
    // the address byte is always sent; later bytes follow the direction bit
    assign m_go = (master_select_bit == M_HOLD) && ctrl[C_MST] &&
        ((data_wr && (ctrl[C_TX] || m_addr)) || (data_rd && !ctrl[C_TX] && !m_addr));
    assign s_go = (master_select_bit == M_IDLE) && slv_wait && addressed &&
        ((data_wr && ctrl[C_TX]) || (data_rd && !ctrl[C_TX]));
    assign go = m_go || s_go;
    assign fall9 = xfer && fall && (bit_cnt == 4'h9);
    assign byte_flag = xfer && fall && !addr_phase &&
        (ctrl[C_FAST_ACK_CONTROL] ? (bit_cnt == 4'h8) : (bit_cnt == 4'h9));
    assign addr_evt = xfer && fall && addr_phase && (bit_cnt == 4'h8) && match;
    assign arb_evt = ((master_select_bit == M_XFER) && xfer && rise && tx_byte && (bit_cnt < 4'h8) &&
        sda_oe_b && !sda_s) ||
        ((master_select_bit == M_IDLE) && ctrl_wr && wd[C_MST] && !ctrl[C_MST] && busy);
    // only the clock-low timeout counts; both bus-high timeouts are ignored
    assign tmo_evt = ctrl[C_SMB] && smb_timeout[T_LOW];
    // a level, so clearing pending before the seen flags raises it again
    assign edge_evt = edge_en && (start_seen || stop_seen);
    assign ev_set = {tmo_evt, edge_evt, arb_evt, addr_evt, byte_flag};

    // ****************************************************************
    // status flags, set always wins over clear
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            pending <= 1'b0;
            arb_lost <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            tcf <= 1'b0;
            addressed <= 1'b0;
            slave_rw <= 1'b0;
            ack_rx <= 1'b0;
            busy <= 1'b0;
            data_reg <= RST_BYTE;
        end
        else
        begin
            pending <= (|ev_set) ||
                (pending && !(wr_fire && (wa == STAT_OFS) && ws[0] && wd[S_PEND]));
            arb_lost <= arb_evt ||
                (arb_lost && !(wr_fire && (wa == STAT_OFS) && ws[0] && wd[S_ARB]));
            start_seen <= start_det ||
                (start_seen && !(wr_fire && (wa == EDGE_OFS) && ws[0] && wd[E_START]));
            stop_seen <= stop_det ||
                (stop_seen && !(wr_fire && (wa == EDGE_OFS) && ws[0] && wd[E_STOP]));
            tcf <= fall9 || (tcf && !(data_wr || data_rd));
            addressed <= addr_evt || (addressed && !ctrl_wr && !stop_det);
            if (addr_evt)
                slave_rw <= shreg[0];
            if (xfer && rise && (bit_cnt == 4'h8) && tx_byte)
                ack_rx <= sda_s;
            if (start_det)
                busy <= 1'b1;
            else if (stop_det)
                busy <= 1'b0;
            if (fall9 && !tx_byte && !addr_phase)
                data_reg <= shreg;
        end
    end

    // ****************************************************************
    // interrupt status, mask and output
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ev_stat <= RST_EV;
            irq <= 1'b0;
        end
        else
        begin
            ev_stat <= ev_set | (ev_stat & ~{5{rd_fire && (araddr == EVST_OFS)}});
            irq <= (|(ev_stat & ev_mask)) || (ctrl[C_IE] && pending);
        end
    end

    // ****************************************************************
    // byte engine: master pacing, bit shifting, slave tracking
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_b || !ctrl[C_EN])
        begin
            master_select_bit <= M_IDLE;
            phase <= 10'h000;
            xfer <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= RST_BYTE;
            tx_byte <= 1'b0;
            addr_phase <= 1'b0;
            m_addr <= 1'b0;
            slv_wait <= 1'b0;
            scl_oe_b <= 1'b1;
            sda_oe_b <= 1'b1;
        end
        else
        begin
            phase <= phase + 10'h001;
            case (master_select_bit)
                M_IDLE:
                    if (ctrl_wr && wd[C_MST] && !ctrl[C_MST] && !busy)
                    begin
                        master_select_bit <= M_START;
                        sda_oe_b <= 1'b0;
                        phase <= 10'h000;
                    end
                M_START:
                    if (phase == HALF_CYC)
                    begin
                        scl_oe_b <= 1'b0;
                        master_select_bit <= M_HOLD;
                        m_addr <= 1'b1;
                    end
                M_HOLD:
                    if (!ctrl[C_MST])
                    begin
                        master_select_bit <= M_STOP;
                        sda_oe_b <= 1'b0;
                        phase <= 10'h000;
                    end
                    else if (ctrl_wr && wd[C_RPT])
                    begin
                        master_select_bit <= M_RPT;
                        sda_oe_b <= 1'b1;
                        phase <= 10'h000;
                    end
                M_XFER:
                    if (!scl_oe_b)
                    begin
                        if (phase == HALF_CYC)
                        begin
                            scl_oe_b <= 1'b1;
                            phase <= 10'h000;
                        end
                    end
                    else if (!scl_s)
                        phase <= 10'h000; // a slave stretching the clock holds us here
                    else if (phase == HALF_CYC)
                    begin
                        scl_oe_b <= 1'b0;
                        phase <= 10'h000;
                    end
                M_RPT:
                begin
                    if (phase == HALF_CYC)
                        scl_oe_b <= 1'b1;
                    if (phase == TWO_HALF)
                        sda_oe_b <= 1'b0;
                    if (phase == THREE_HALF)
                    begin
                        scl_oe_b <= 1'b0;
                        master_select_bit <= M_HOLD;
                        m_addr <= 1'b1;
                    end
                end
                M_STOP:
                begin
                    if (phase == HALF_CYC)
                        scl_oe_b <= 1'b1;
                    if (phase == TWO_HALF)
                    begin
                        sda_oe_b <= 1'b1;
                        master_select_bit <= M_IDLE;
                    end
                end
                default: master_select_bit <= M_IDLE;
            endcase

            if (go)
            begin
                xfer <= 1'b1;
                bit_cnt <= 4'h0;
                tx_byte <= data_wr;
                addr_phase <= 1'b0;
                slv_wait <= 1'b0;
                phase <= 10'h000;
                if (data_wr)
                begin
                    shreg <= wd[7:0];
                    sda_oe_b <= wd[7];
                end
                if (s_go)
                    scl_oe_b <= 1'b1;
                if (m_go)
                begin
                    master_select_bit <= M_XFER;
                    m_addr <= 1'b0;
                end
            end
            else if (xfer && rise)
            begin
                // the ninth rise is the ack bit and must not disturb the byte
                if (bit_cnt < 4'h8)
                    shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            else if (xfer && fall)
            begin
                if (bit_cnt < 4'h8)
                    sda_oe_b <= !tx_byte || shreg[7];
                else if (bit_cnt == 4'h8)
                begin
                    sda_oe_b <= tx_byte || (addr_phase ? !match : ctrl[C_ACKV]);
                    if (addr_phase && !match)
                    begin
                        xfer <= 1'b0;
                        addr_phase <= 1'b0;
                    end
                end
                else
                begin
                    // byte over: hold the clock low until software responds
                    sda_oe_b <= 1'b1;
                    xfer <= 1'b0;
                    addr_phase <= 1'b0;
                    if (master_select_bit == M_XFER)
                        master_select_bit <= M_HOLD;
                    else
                    begin
                        scl_oe_b <= 1'b0;
                        slv_wait <= 1'b1;
                    end
                end
            end

            if ((start_det || stop_det) && (master_select_bit == M_IDLE))
            begin
                xfer <= start_det;
                addr_phase <= start_det;
                tx_byte <= 1'b0;
                bit_cnt <= 4'h0;
                slv_wait <= 1'b0;
                sda_oe_b <= 1'b1;
                scl_oe_b <= 1'b1;
            end

            if (arb_evt && (master_select_bit == M_XFER))
            begin
                master_select_bit <= M_IDLE;
                xfer <= 1'b0;
                scl_oe_b <= 1'b1;
                sda_oe_b <= 1'b1;
            end
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge clock)
    begin
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end

endmodule // i2c_data_port

/* File: verif/i2c_data_port_properties.sv */
`timescale 1ns/1ns
// ****
// bus, line and reset checks
// ****
module i2c_data_port_properties (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic scl_out,
    input wire logic scl_oe_b,
    input wire logic sda_out,
    input wire logic sda_oe_b,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    chk_reset_quiet:
        assert property (disable iff (1'b0) !rst_b |=> !irq && !bvalid && !rvalid
            && scl_oe_b && sda_oe_b) else $error("outputs active in reset");
    // a high drive would fight other parties on the wire
    chk_open_drain:
        assert property (!scl_out && !sda_out) else $error("line driven high");
    chk_write_answer:
        assert property (s_wr_take |=> !bvalid && !awready && !wready ##1 bvalid)
            else $error("write not answered");
    chk_write_release:
        assert property (bvalid && bready |=> !bvalid && awready && wready)
            else $error("write not released");
    chk_read_answer:
        assert property (s_rd_take |=> rvalid && !arready) else $error("read not answered");
    chk_read_release:
        assert property (rvalid && rready |=> !rvalid && arready)
            else $error("read not released");
    chk_unmapped_read:
        assert property (s_rd_take ##0 araddr > 8'h18 |=> rresp == 2'h2)
            else $error("unmapped read accepted");
    // only a register access may take the request down
    chk_irq_cause:
        assert property ($past(rst_b) && $fell(irq) |-> bvalid || rvalid || $past(bvalid)
            || $past(rvalid)) else $error("irq fell without access");
endmodule // i2c_data_port_properties

/* File: verif/i2c_slave_model.sv */
`timescale 1ns/1ns
// ****
// far slave: acks writes, sends RD_BYTE for every read byte until a missing ack
// ****
module i2c_slave_model #(
    parameter logic [7:0] RD_BYTE = 8'h96
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_rel,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic rd = 1'b0;
    logic first = 1'b0;
    int n = 9;
    initial sda_rel = 1'b1;
    initial got = 8'h00;
    always @(negedge sda) if (scl)
    begin
        n = -1;
        first = 1'b1;
        rd = 1'b0;
    end
    always @(posedge scl)
    begin
        if (n >= 0 && n < 8) sh = {sh[6:0], sda};
        // a missing ack ends the read, so the line is free for the stop
        if (n == 8 && sda) rd = 1'b0;
    end
    always @(negedge scl)
    begin
        n = n + 1;
        if (n == 8)
        begin
            if (first) rd = sh[0];
            if (first || !rd) got = sh;
            sda_rel = !(first || !rd);
            first = 1'b0;
        end
        else if (n == 9)
        begin
            n = 0;
            sda_rel = rd ? RD_BYTE[7] : 1'b1;
        end
        else sda_rel = rd ? RD_BYTE[7 - n] : 1'b1;
    end
endmodule // i2c_slave_model

/* File: verif/i2c_data_port_and_irq_flag_test.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("MISMATCH %s exp %h got %h", n, e, g); end end
// ****
// register, interrupt and transfer tests
// ****
module i2c_data_port_and_irq_flag_test;
    import i2c_pkg::*;
    localparam logic [17:0] ROWS [8] = '{{CTRL_OFS, 10'h0}, {DATA_OFS, 10'h0},
        {SADDR_OFS, 10'h0}, {STAT_OFS, 10'h0}, {EDGE_OFS, 10'h0}, {EVST_OFS, 10'h0},
        {EVMASK_OFS, 10'h0}, {8'h1C, 8'h00, RESP_SLVERR}};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, got;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [2:0] smb_timeout = 3'h0;
    logic ext_sda = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, scl_oe_b, sda_oe_b, sda_rel;
    logic [1:0] bresp, rresp, rr;
    int fail_count = 0;
    int cmp_count = 0;
    wire scl = scl_oe_b;
    // ext_sda stands for a second master on the data line
    wire sda = sda_oe_b & sda_rel & ext_sda;
    always #5 clock = ~clock;
    i2c_data_port u_dut (.clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .scl_in(scl), .scl_out(), .scl_oe_b(scl_oe_b),
        .sda_in(sda), .sda_out(), .sda_oe_b(sda_oe_b), .ext_addr_match(1'b0),
        .smb_timeout(smb_timeout), .irq(irq));
    i2c_slave_model u_far (.scl(scl), .sda(sda), .sda_rel(sda_rel), .got(got));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                bready <= 1'b0;
                rr = bresp;
            end
        end while (awvalid || wvalid || bready);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin rready <= 1'b0; rd = rdata; rr = rresp; end
        end while (arvalid || rready);
    endtask
    task automatic pend(input logic e);
        rdr(STAT_OFS);
        `CHK("pending", e, rd[S_PEND])
    endtask
    // irq is registered from the flags, so let it settle first
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clock);
        `CHK("irq", e, irq)
    endtask
    task automatic wait_pend();
        rd = 32'h0;
        for (int i = 0; i < 20 && !rd[S_PEND]; i++)
        begin
            repeat (500) @(posedge clock);
            rdr(STAT_OFS);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #900000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        foreach (ROWS[i])
        begin
            rdr(ROWS[i][17:10]);
            `CHK("reg", ROWS[i][9:2], rd[7:0])
            `CHK("resp", ROWS[i][1:0], rr)
        end
        wr(8'h1C, 8'h00);
        `CHK("bresp", RESP_SLVERR, rr)
        wr(CTRL_OFS, 8'h81);
        `CHK("bresp ok", RESP_OKAY, rr)
        for (int t = 2; t >= 0; t--)
        begin
            smb_timeout <= 3'h1 << t;
            @(posedge clock);
            smb_timeout <= 3'h0;
            pend(t == 0);
        end
        wr(EVMASK_OFS, 8'h10);
        irq_is(1'b1);
        rdr(EVST_OFS);
        `CHK("events", 8'h10, rd[7:0])
        irq_is(1'b0);
        wr(STAT_OFS, 8'h00);
        wr(CTRL_OFS, 8'hC1);
        irq_is(1'b1);
        pend(1'b1);
        wr(STAT_OFS, 8'h02);
        irq_is(1'b0);
        wr(CTRL_OFS, 8'hF0);
        // the address byte is only taken once the start is on the wire
        repeat (300) @(posedge clock);
        wr(DATA_OFS, 8'hA4);
        wait_pend();
        `CHK("byte done", 1'b1, rd[S_PEND])
        `CHK("address", 8'hA4, got)
        `CHK("ack", 1'b0, rd[S_ACK])
        wr(STAT_OFS, 8'h02);
        wr(DATA_OFS, 8'h3C);
        wait_pend();
        `CHK("data", 8'h3C, got)
        wr(STAT_OFS, 8'h02);
        rdr(DATA_OFS);
        repeat (3000) @(posedge clock);
        pend(1'b0);
        wr(CTRL_OFS, 8'hC0);
        repeat (3000) @(posedge clock);
        pend(1'b0);
        wr(EDGE_OFS, 8'h20);
        pend(1'b1);
        wr(STAT_OFS, 8'h02);
        pend(1'b1);
        wr(EDGE_OFS, 8'h70);
        wr(STAT_OFS, 8'h02);
        pend(1'b0);
        wr(EDGE_OFS, 8'h50);
        wr(CTRL_OFS, 8'hB0);
        repeat (300) @(posedge clock);
        wr(DATA_OFS, 8'hA5);
        wait_pend();
        wr(STAT_OFS, 8'h02);
        wr(CTRL_OFS, 8'hA8);
        rdr(DATA_OFS);
        wait_pend();
        `CHK("rx done", 1'b1, rd[S_PEND])
        wr(CTRL_OFS, 8'h88);
        rdr(DATA_OFS);
        `CHK("rx byte", 8'h96, rd[7:0])
        repeat (3000) @(posedge clock);
        `CHK("idle", 2'b11, {scl, sda})
        wr(STAT_OFS, 8'h02);
        // another master starts, so our own start attempt loses the bus
        ext_sda <= 1'b0;
        repeat (10) @(posedge clock);
        wr(CTRL_OFS, 8'hA0);
        pend(1'b1);
        `CHK("arb lost", 1'b1, rd[S_ARB])
        ext_sda <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rdr(DATA_OFS);
        `CHK("reset data", 8'h00, rd[7:0])
        report_and_stop();
    end
endmodule // i2c_data_port_and_irq_flag_test
bind i2c_data_port i2c_data_port_properties u_chk (.clock(clock), .rst_b(rst_b),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_out(scl_out),
    .scl_oe_b(scl_oe_b), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .irq(irq));
